// file: logic/cbu_map.svh
`ifndef CBU_MAP_SVH
`define CBU_MAP_SVH

// instruction word layout (24-bit program word)
`define CBU_IW_W          24
`define CBU_PC_W          23
`define CBU_CLASS_HI      23
`define CBU_CLASS_LO      20
`define CBU_COND_HI       19
`define CBU_COND_LO       16
`define CBU_OFS_HI        15
`define CBU_OFS_LO        0
`define CBU_OFS_W         16

// opcode class nibble shared by all flag-conditioned relative branches
`define CBU_CLASS_BRANCH  4'h3
`define CBU_COND_GE       4'hd
`define CBU_COND_GEU      4'h1
`define CBU_COND_GT       4'hc
`define CBU_COND_GTU      4'he
`define CBU_COND_LE       4'h4

// status word flag positions
`define CBU_SW_W          16
`define CBU_SW_C          0
`define CBU_SW_Z          1
`define CBU_SW_OV         2
`define CBU_SW_N          3

`define CBU_NEXT_STEP     23'h00_0002
`define CBU_PC_RESET      23'h00_0000
`define CBU_NOP_WORD      24'h00_0000
`define CBU_TAKEN_CYCLES  2
`define CBU_SEQ_CYCLES    1

`endif

// file: logic/cbu_pkg.sv
package cbu_pkg;
    typedef enum logic [5:0] {
        CBU_OP_NONE = 6'b00_0001,
        CBU_OP_GE   = 6'b00_0010,
        CBU_OP_GEU  = 6'b00_0100,
        CBU_OP_GT   = 6'b00_1000,
        CBU_OP_GTU  = 6'b01_0000,
        CBU_OP_LE   = 6'b10_0000
    } cbu_op_e;

    typedef enum logic [1:0] {
        CBU_ST_RUN  = 2'b01,
        CBU_ST_BUBB = 2'b10
    } cbu_state_e;

    typedef logic [22:0] cbu_pc_t;
endpackage

// file: logic/cbu_dec_if.sv
`include "cbu_map.svh"

interface cbu_dec_if;
    logic [`CBU_IW_W-1:0]  instr;
    logic [`CBU_SW_W-1:0]  status_word;
    cbu_pkg::cbu_op_e      op;
    logic                  is_branch;
    logic                  cond_true;
    logic [`CBU_OFS_W-1:0] branch_word_offset;

    modport decoder (input instr, input status_word,
                     output op, output is_branch, output cond_true, output branch_word_offset);
    modport core    (output instr, output status_word,
                     input op, input is_branch, input cond_true, input branch_word_offset);
endinterface

// file: logic/cbu_decode.sv
`include "cbu_map.svh"

module cbu_decode (
    cbu_dec_if.decoder dec   // instruction and flags in, condition out
);
    logic [3:0] class_nib;
    logic [3:0] cond_nib;
    logic       fc;
    logic       fz;
    logic       fov;
    logic       fn;

    always_comb begin
        class_nib              = dec.instr[`CBU_CLASS_HI:`CBU_CLASS_LO];
        cond_nib               = dec.instr[`CBU_COND_HI:`CBU_COND_LO];
        dec.branch_word_offset = dec.instr[`CBU_OFS_HI:`CBU_OFS_LO];
        fc                     = dec.status_word[`CBU_SW_C];
        fz                     = dec.status_word[`CBU_SW_Z];
        fov                    = dec.status_word[`CBU_SW_OV];
        fn                     = dec.status_word[`CBU_SW_N];
        dec.op                 = cbu_pkg::CBU_OP_NONE;
        dec.cond_true          = 1'b0;
        if (class_nib == `CBU_CLASS_BRANCH) begin
            case (cond_nib)
                `CBU_COND_GE: begin
                    dec.op        = cbu_pkg::CBU_OP_GE;
                    dec.cond_true = (fn == fov);
                end
                `CBU_COND_GEU: begin
                    // one encoding for carry-set and unsigned at-least
                    dec.op        = cbu_pkg::CBU_OP_GEU;
                    dec.cond_true = fc;
                end
                `CBU_COND_GT: begin
                    dec.op        = cbu_pkg::CBU_OP_GT;
                    dec.cond_true = !fz && (fn == fov);
                end
                `CBU_COND_GTU: begin
                    dec.op        = cbu_pkg::CBU_OP_GTU;
                    dec.cond_true = fc && !fz;
                end
                `CBU_COND_LE: begin
                    dec.op        = cbu_pkg::CBU_OP_LE;
                    dec.cond_true = fz || (fn != fov);
                end
                default: begin
                    dec.op        = cbu_pkg::CBU_OP_NONE;
                    dec.cond_true = 1'b0;
                end
            endcase
        end
        dec.is_branch = (dec.op != cbu_pkg::CBU_OP_NONE);
    end
endmodule

// file: logic/cbu_target.sv
`include "cbu_map.svh"

module cbu_target (
    input  wire logic [`CBU_PC_W-1:0]   pc,          // address of the branch word
    input  wire logic [`CBU_OFS_W-1:0]  ofs,         // signed word offset
    output logic      [`CBU_PC_W-1:0]   next_seq,    // pc + 2
    output logic      [`CBU_PC_W-1:0]   target       // (pc + 2) + 2*ofs
);
    logic [`CBU_PC_W-1:0] ofs_bytes;

    always_comb begin
        // sign-extend then double: reach is -32768 to +32767 words from pc + 2
        ofs_bytes = {{(`CBU_PC_W-`CBU_OFS_W-1){ofs[`CBU_OFS_W-1]}}, ofs, 1'b0};
        next_seq  = pc + `CBU_NEXT_STEP;
        target    = next_seq + ofs_bytes;
    end
endmodule

// file: logic/cbu_core.sv
`include "cbu_map.svh"

module cbu_core (
    input  wire logic                    ref_clk,        // core clock, 40 MHz
    input  wire logic                    rst_n,          // synchronous reset, low active
    input  wire logic                    instr_valid,    // fetch presents a word this cycle
    input  wire logic [`CBU_IW_W-1:0]    instr_word,     // fetched instruction word
    input  wire logic [`CBU_PC_W-1:0]    instr_pc,       // address of instr_word
    input  wire logic [`CBU_SW_W-1:0]    status_word,    // current status flags
    output logic                         pc_load,        // one-cycle: fetch redirect
    output logic      [`CBU_PC_W-1:0]    pc_target,      // new program counter
    output logic                         exec_nop,       // this cycle executes a bubble
    output logic      [`CBU_IW_W-1:0]    exec_word,      // word actually executed
    output logic                         branch_busy,    // branch holds the issue slot
    output logic      [`CBU_SW_W-1:0]    status_out,     // flags after this unit
    output logic                         br_done,        // pulse: a branch retired
    output logic                         br_taken,       // registered taken flag
    output logic                         br_is_carry,    // disassembly view: carry form
    output logic      [`CBU_PC_W-1:0]    seq_pc          // next sequential address
);
    cbu_dec_if dec ();

    logic [`CBU_PC_W-1:0] next_seq;
    logic [`CBU_PC_W-1:0] target;
    logic                 accept;
    logic                 take;

    cbu_pkg::cbu_state_e  state_r;
    cbu_pkg::cbu_state_e  state_nxt;
    logic                 pc_load_r;
    logic                 pc_load_nxt;
    logic [`CBU_PC_W-1:0] pc_target_r;
    logic [`CBU_PC_W-1:0] pc_target_nxt;
    logic [`CBU_IW_W-1:0] exec_word_r;
    logic [`CBU_IW_W-1:0] exec_word_nxt;
    logic                 exec_nop_r;
    logic                 exec_nop_nxt;
    logic                 done_r;
    logic                 done_nxt;
    logic                 taken_r;
    logic                 taken_nxt;
    logic                 carry_r;
    logic                 carry_nxt;
    logic [`CBU_PC_W-1:0] seq_pc_r;
    logic [`CBU_PC_W-1:0] seq_pc_nxt;

    cbu_decode u_decode (
        .dec (dec)
    );

    cbu_target u_target (
        .pc       (instr_pc),
        .ofs      (dec.branch_word_offset),
        .next_seq (next_seq),
        .target   (target)
    );

    assign dec.instr       = instr_word;
    assign dec.status_word = status_word;

    // words offered during the bubble are refused, not queued
    assign accept = instr_valid && (state_r == cbu_pkg::CBU_ST_RUN);
    assign take   = accept && dec.is_branch && dec.cond_true;

    // a taken branch owns the following cycle for its bubble
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            cbu_pkg::CBU_ST_RUN: begin
                if (take) begin
                    state_nxt = cbu_pkg::CBU_ST_BUBB;
                end
            end
            cbu_pkg::CBU_ST_BUBB: begin
                state_nxt = cbu_pkg::CBU_ST_RUN;
            end
            default: begin
                state_nxt = cbu_pkg::CBU_ST_RUN;
            end
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            state_r <= cbu_pkg::CBU_ST_RUN;
        end else begin
            state_r <= state_nxt;
        end
    end

    // one-cycle pulse, so fetch reloads exactly once per taken branch
    always_comb begin
        pc_load_nxt = 1'b0;
        case (state_r)
            cbu_pkg::CBU_ST_RUN: begin
                if (take) begin
                    pc_load_nxt = 1'b1;
                end
            end
            cbu_pkg::CBU_ST_BUBB: begin
                pc_load_nxt = 1'b0;
            end
            default: begin
                pc_load_nxt = 1'b0;
            end
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            pc_load_r <= 1'b0;
        end else begin
            pc_load_r <= pc_load_nxt;
        end
    end

    always_comb begin
        pc_target_nxt = pc_target_r;
        case (state_r)
            cbu_pkg::CBU_ST_RUN: begin
                if (take) begin
                    pc_target_nxt = target;
                end
            end
            cbu_pkg::CBU_ST_BUBB: begin
                pc_target_nxt = pc_target_r;
            end
            default: begin
                pc_target_nxt = pc_target_r;
            end
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            pc_target_r <= `CBU_PC_RESET;
        end else begin
            pc_target_r <= pc_target_nxt;
        end
    end

    // the word fetched behind a taken branch is discarded, never executed
    always_comb begin
        exec_word_nxt = exec_word_r;
        case (state_r)
            cbu_pkg::CBU_ST_RUN: begin
                if (accept) begin
                    exec_word_nxt = instr_word;
                end
            end
            cbu_pkg::CBU_ST_BUBB: begin
                exec_word_nxt = `CBU_NOP_WORD;
            end
            default: begin
                exec_word_nxt = exec_word_r;
            end
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            exec_word_r <= `CBU_NOP_WORD;
        end else begin
            exec_word_r <= exec_word_nxt;
        end
    end

    always_comb begin
        exec_nop_nxt = 1'b0;
        case (state_r)
            cbu_pkg::CBU_ST_RUN: begin
                exec_nop_nxt = 1'b0;
            end
            cbu_pkg::CBU_ST_BUBB: begin
                exec_nop_nxt = 1'b1;
            end
            default: begin
                exec_nop_nxt = 1'b0;
            end
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            exec_nop_r <= 1'b0;
        end else begin
            exec_nop_r <= exec_nop_nxt;
        end
    end

    // done is a pulse; taken and the carry view hold until the next branch
    always_comb begin
        done_nxt = 1'b0;
        case (state_r)
            cbu_pkg::CBU_ST_RUN: begin
                if (accept && dec.is_branch) begin
                    done_nxt = 1'b1;
                end
            end
            cbu_pkg::CBU_ST_BUBB: begin
                done_nxt = 1'b0;
            end
            default: begin
                done_nxt = 1'b0;
            end
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            done_r <= 1'b0;
        end else begin
            done_r <= done_nxt;
        end
    end

    always_comb begin
        taken_nxt = taken_r;
        case (state_r)
            cbu_pkg::CBU_ST_RUN: begin
                if (accept && dec.is_branch) begin
                    taken_nxt = dec.cond_true;
                end
            end
            cbu_pkg::CBU_ST_BUBB: begin
                taken_nxt = taken_r;
            end
            default: begin
                taken_nxt = taken_r;
            end
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            taken_r <= 1'b0;
        end else begin
            taken_r <= taken_nxt;
        end
    end

    always_comb begin
        carry_nxt = carry_r;
        case (state_r)
            cbu_pkg::CBU_ST_RUN: begin
                if (accept && dec.is_branch) begin
                    carry_nxt = (dec.op == cbu_pkg::CBU_OP_GEU);
                end
            end
            cbu_pkg::CBU_ST_BUBB: begin
                carry_nxt = carry_r;
            end
            default: begin
                carry_nxt = carry_r;
            end
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            carry_r <= 1'b0;
        end else begin
            carry_r <= carry_nxt;
        end
    end

    // every accepted word, branch or not, is one program word long
    always_comb begin
        seq_pc_nxt = seq_pc_r;
        case (state_r)
            cbu_pkg::CBU_ST_RUN: begin
                if (accept) begin
                    seq_pc_nxt = next_seq;
                end
            end
            cbu_pkg::CBU_ST_BUBB: begin
                seq_pc_nxt = seq_pc_r;
            end
            default: begin
                seq_pc_nxt = seq_pc_r;
            end
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            seq_pc_r <= `CBU_PC_RESET;
        end else begin
            seq_pc_r <= seq_pc_nxt;
        end
    end

    assign pc_load     = pc_load_r;
    assign pc_target   = pc_target_r;
    assign exec_nop    = exec_nop_r;
    assign exec_word   = exec_word_r;
    assign branch_busy = (state_r == cbu_pkg::CBU_ST_BUBB);
    assign status_out  = status_word;
    assign br_done     = done_r;
    assign br_taken    = taken_r;
    assign br_is_carry = carry_r;
    assign seq_pc      = seq_pc_r;
endmodule

// file: test/cbu_core_sva.sv
module cbu_core_sva (
    input wire logic        ref_clk,      // core clock
    input wire logic        rst_n,        // sync reset, low active
    input wire logic        instr_valid,  // word offered
    input wire logic [23:0] instr_word,   // offered word
    input wire logic [22:0] instr_pc,     // its address
    input wire logic [15:0] status_word,  // flags in
    input wire logic        pc_load,      // redirect pulse
    input wire logic [22:0] pc_target,    // redirect address
    input wire logic        exec_nop,     // bubble pulse
    input wire logic [23:0] exec_word,    // executed word
    input wire logic        branch_busy,  // slot held
    input wire logic [15:0] status_out,   // flags out
    input wire logic        br_done,      // branch retired
    input wire logic        br_taken,     // taken result
    input wire logic        br_is_carry,  // carry view
    input wire logic [22:0] seq_pc        // next sequential
);
    timeunit 1ns;
    timeprecision 1ps;
    wire [3:0]  cc = instr_word[19:16];
    wire        n = status_word[3];
    wire        v = status_word[2];
    wire        z = status_word[1];
    wire        c = status_word[0];
    wire        is_c = cc == 4'h1;
    wire        ok_ge = n == v;
    wire        ok_gt = !z && n == v;
    wire        ok_gtu = c && !z;
    wire        ok_le = z || n != v;
    wire        hit = instr_valid && !branch_busy && instr_word[23:20] == 4'h3
                      && (cc == 4'hd || is_c || cc == 4'hc || cc == 4'he || cc == 4'h4);
    wire        ok = cc == 4'hd ? ok_ge : is_c ? c : cc == 4'hc ? ok_gt : cc == 4'he ? ok_gtu : ok_le;
    wire [22:0] nxt = instr_pc + 23'h00_0002;
    wire [22:0] tgt = nxt + {{6{instr_word[15]}}, instr_word[15:0], 1'b0};
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    sequence s_redirect;
        pc_load && branch_busy && pc_target == $past(tgt);
    endsequence
    sequence s_bubble;
        exec_nop && !pc_load && exec_word == 24'h00_0000;
    endsequence
    ge_decision_a: assert property (hit && cc == 4'hd |=> br_taken == $past(ok_ge)) else $error("ge wrong");
    geu_decision_a: assert property (hit && is_c |=> br_taken == $past(c)) else $error("geu wrong");
    carry_view_a: assert property (hit |=> br_is_carry == $past(is_c)) else $error("carry view wrong");
    gt_decision_a: assert property (hit && cc == 4'hc |=> br_taken == $past(ok_gt)) else $error("gt wrong");
    gtu_decision_a: assert property (hit && cc == 4'he |=> br_taken == $past(ok_gtu)) else $error("gtu wrong");
    le_decision_a: assert property (hit && cc == 4'h4 |=> br_taken == $past(ok_le)) else $error("le wrong");
    taken_walk_a: assert property (hit && ok |=> s_redirect ##1 s_bubble) else $error("taken walk wrong");
    skip_walk_a: assert property (hit && !ok |=> br_done && !pc_load && !branch_busy && seq_pc == $past(nxt))
        else $error("skip walk wrong");
    flags_kept_a: assert property (status_out == status_word) else $error("flags changed");
endmodule

// file: test/cbu_fetch_model.sv
module cbu_fetch_model (
    input  wire logic        ref_clk,      // core clock
    input  wire logic        rst_n,        // sync reset
    input  wire logic        instr_valid,  // word offered
    input  wire logic [22:0] instr_pc,     // its address
    input  wire logic        branch_busy,  // slot held
    input  wire logic        pc_load,      // redirect pulse
    input  wire logic [22:0] pc_target,    // redirect address
    output logic      [22:0] fetch_pc      // fetch pointer
);
    timeunit 1ns;
    timeprecision 1ps;
    // redirect wins: the prefetched sequential word is dropped
    always_ff @(posedge ref_clk) begin
        if (!rst_n) fetch_pc <= 23'h00_0000;
        else if (pc_load) fetch_pc <= pc_target;
        else if (instr_valid && !branch_busy) fetch_pc <= instr_pc + 23'h00_0002;
    end
endmodule

// file: test/conditional_branch_unit_bench.sv
module conditional_branch_unit_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic        ref_clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        instr_valid = 1'b0;
    logic [23:0] instr_word = 24'h00_0000;
    logic [22:0] instr_pc = 23'h00_0000;
    logic [15:0] status_word = 16'h0000;
    logic        pc_load, exec_nop, branch_busy, br_done, br_taken, br_is_carry;
    logic [22:0] pc_target, seq_pc, fetch_pc;
    logic [23:0] exec_word;
    logic [15:0] status_out;
    int          n_fail = 0;
    int          checks_done = 0;
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin n_fail++; $display("Error %0t: %0h not %0h", $time, a, e); end end
    always #12.5 ref_clk = ~ref_clk;
    cbu_core dut (.ref_clk, .rst_n, .instr_valid, .instr_word, .instr_pc, .status_word, .pc_load, .pc_target,
                  .exec_nop, .exec_word, .branch_busy, .status_out, .br_done, .br_taken, .br_is_carry, .seq_pc);
    cbu_fetch_model fetch (.ref_clk, .rst_n, .instr_valid, .instr_pc, .branch_busy, .pc_load, .pc_target, .fetch_pc);
    task automatic step();
        @(posedge ref_clk);
        #2;
    endtask
    task automatic do_branch(input logic [3:0] cc, input logic [15:0] sw, input logic [15:0] ofs,
                             input logic [22:0] pc, input logic tk);
        logic [22:0] exp_t;
        logic [23:0] exp_w;
        exp_t = pc + 23'h00_0002 + (23'(signed'(ofs)) << 1);
        exp_w = {4'h3, cc, ofs};
        instr_valid = 1'b1;
        instr_word = exp_w;
        instr_pc = pc;
        status_word = sw;
        step();
        instr_valid = 1'b0;
        `CHK(br_done, 1'b1)
        `CHK(br_taken, tk)
        `CHK(pc_load, tk)
        `CHK(seq_pc, pc + 23'h00_0002)
        `CHK(status_out, sw)
        `CHK(br_is_carry, cc == 4'h1)
        if (tk) `CHK(pc_target, exp_t)
        `CHK(exec_word, exp_w)
        `CHK(branch_busy, tk)
        step();
        `CHK(exec_nop, tk)
        `CHK(br_done, 1'b0)
        `CHK(pc_load, 1'b0)
        `CHK(branch_busy, 1'b0)
        if (tk) begin
            `CHK(fetch_pc, exp_t)
            `CHK(exec_word, 24'h00_0000)
        end
    endtask
    task automatic t_conds();
        do_branch(4'hd, 16'h0000, 16'h0003, 23'h00_2000, 1'b1);
        do_branch(4'hd, 16'h0008, 16'h0003, 23'h00_2000, 1'b0);
        do_branch(4'hd, 16'h000c, 16'h0003, 23'h00_2000, 1'b1);
        do_branch(4'h1, 16'h0001, 16'h0005, 23'h00_2000, 1'b1);
        do_branch(4'h1, 16'h000e, 16'h0005, 23'h00_2000, 1'b0);
        do_branch(4'hc, 16'h0000, 16'h0005, 23'h00_2000, 1'b1);
        do_branch(4'hc, 16'h000e, 16'h0005, 23'h00_2000, 1'b0);
        do_branch(4'hc, 16'h0008, 16'h0005, 23'h00_2000, 1'b0);
        do_branch(4'he, 16'h0001, 16'h0005, 23'h00_2000, 1'b1);
        do_branch(4'he, 16'h0003, 16'h0005, 23'h00_2000, 1'b0);
        do_branch(4'he, 16'h0000, 16'h0005, 23'h00_2000, 1'b0);
        do_branch(4'h4, 16'h0002, 16'h0005, 23'h00_2000, 1'b1);
        do_branch(4'h4, 16'h0004, 16'h0005, 23'h00_2000, 1'b1);
        do_branch(4'h4, 16'h000c, 16'h0005, 23'h00_2000, 1'b0);
    endtask
    task automatic t_reach();
        do_branch(4'h1, 16'h0001, 16'hfffb, 23'h00_623c, 1'b1);
        do_branch(4'hd, 16'h0000, 16'h8000, 23'h00_6230, 1'b1);
        do_branch(4'he, 16'h0001, 16'h7fff, 23'h7f_fff0, 1'b1);
    endtask
    task automatic t_refuse();
        instr_valid = 1'b1;
        instr_word = 24'h3d_0004;
        status_word = 16'h0000;
        step();
        step();
        `CHK(br_done, 1'b0)
        `CHK(pc_load, 1'b0)
        instr_word = 24'h20_0004;
        step();
        instr_valid = 1'b0;
        `CHK(br_done, 1'b0)
        `CHK(pc_load, 1'b0)
    endtask
    task automatic complete_run();
        if (n_fail == 0 && checks_done > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    initial begin
        repeat (5) @(posedge ref_clk);
        #2 rst_n = 1'b1;
        `CHK(pc_load, 1'b0)
        `CHK(branch_busy, 1'b0)
        t_conds();
        t_reach();
        t_refuse();
        complete_run();
    end
    initial begin
        #50000;
        n_fail++;
        complete_run();
    end
endmodule
bind cbu_core cbu_core_sva chk (.ref_clk, .rst_n, .instr_valid, .instr_word, .instr_pc, .status_word, .pc_load,
    .pc_target, .exec_nop, .exec_word, .branch_busy, .status_out, .br_done, .br_taken, .br_is_carry, .seq_pc);
